// ---- inc/tw_pkg.sv ----
// shared constants and types of the 8-bit waveform timer
// assumes one clock domain and an AXI4-Lite register slave in front of the timer
package tw_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMP_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_B = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_DIR   = 8'h14;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // waveform mode codes
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_FF  = 3'h3;
  localparam logic [2:0] WGM_PHASE_CA = 3'h5;
  localparam logic [2:0] WGM_FAST_CA  = 3'h7;

  // channel output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // counter extremes
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // prescaler masks: divide by mask+1
  localparam logic [9:0] DIV_MASK_1    = 10'h000;
  localparam logic [9:0] DIV_MASK_8    = 10'h007;
  localparam logic [9:0] DIV_MASK_32   = 10'h01F;
  localparam logic [9:0] DIV_MASK_64   = 10'h03F;
  localparam logic [9:0] DIV_MASK_128  = 10'h07F;
  localparam logic [9:0] DIV_MASK_256  = 10'h0FF;
  localparam logic [9:0] DIV_MASK_1024 = 10'h3FF;

  // bit positions in the flag register
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;

  // reset values
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [2:0] FLG_RST = 3'h0;

  // control register layout, bit 0 upward: mode, com a, com b, clock select
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] wgm;
  } tw_ctrl_t;

  localparam tw_ctrl_t CTRL_RST = '0;

  // counting behaviour, one-hot
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_CTC    = 4'b0010,
    MODE_FAST   = 4'b0100,
    MODE_PHASE  = 4'b1000
  } tw_mode_t;

endpackage

// ---- logic/tw_prescaler.sv ----
// timer clock prescaler: one-cycle tick every N bus clocks
// assumes clk_sel comes from a register in the same clock domain
`timescale 1ns/1ns
module tw_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clk_sel,
  output logic            tick
);

  logic [9:0] div_cnt_q;
  logic [9:0] mask;
  logic       run;

  // select 0 stops the timer
  always_comb begin
    run  = 1'b1;
    mask = tw_pkg::DIV_MASK_1;
    case (clk_sel)
      3'h0: run  = 1'b0;
      3'h1: mask = tw_pkg::DIV_MASK_1;
      3'h2: mask = tw_pkg::DIV_MASK_8;
      3'h3: mask = tw_pkg::DIV_MASK_32;
      3'h4: mask = tw_pkg::DIV_MASK_64;
      3'h5: mask = tw_pkg::DIV_MASK_128;
      3'h6: mask = tw_pkg::DIV_MASK_256;
      default: mask = tw_pkg::DIV_MASK_1024;
    endcase
  end

  // free-running divider; a change of factor may shorten the first period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 10'h000;
      tick      <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 10'h001;
      tick      <= run && ((div_cnt_q & mask) == mask);
    end
  end

endmodule // tw_prescaler

// ---- logic/tw_timer8.sv ----
// 8-bit timer with clear-on-match, fast pwm and phase-correct pwm waveforms
// assumes an AXI4-Lite master on aclk and port pins driven from the wave outputs
//
// How it works
// - mode 2 clears the count when it equals compare a, setting top
// - clear-on-match mode writes compare a straight into the active value
// - compare a written below the count is missed until wrap from 0xFF to 0x00
// - clear-on-match with output mode 1 toggles wave a on each match
// - clear-on-match sets the compare a flag whenever the count hits top
// - clear-on-match sets overflow only when count goes from max to 0x00
// - modes 3 and 7 count up to top, 0xFF or compare a, then restart
// - fast pwm clears the count one timer tick after it equals top
// - fast pwm mode two clears on match, sets at bottom; three the reverse
// - fast pwm sets overflow each time the count reaches top
// - fast pwm keeps compare writes in a buffer, not the active value
// - fast pwm with output mode 1 toggles the wave on each match
// - fast pwm compare zero gives narrow pulses; compare max a constant level
// - modes 1 and 5 count up to top then down to zero, repeating
// - phase-correct turns at top, holding top for exactly one tick
// - phase-correct non-inverting clears on up match, sets on down match
// - phase-correct sets overflow each time the count reaches zero
// - phase-correct compare zero gives constant low, max constant high
// - phase-correct at max acts as down match; leaving max moves at period start
// - phase-correct start above compare misses the up-count match and its transition
// - a wave reaches its pin only while the pin direction is output
// - the counter runs at the bus clock divided by 1,8,32,64,128,256,1024
// - pwm modes load buffered compare values only at top or bottom
// - output mode 0 leaves the wave unchanged on a match
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
module tw_timer8 (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wave_out_a,
  output logic             wave_out_a_oe,
  output logic             wave_out_b,
  output logic             wave_out_b_oe
);

  // new output level after an action; lvl is what a non-inverting match gives
  function automatic logic wave_act(input logic [1:0] com, input logic cur,
                                    input logic lvl);
    case (com)
      tw_pkg::COM_TOGGLE: wave_act = ~cur;
      tw_pkg::COM_CLEAR:  wave_act = lvl;
      tw_pkg::COM_SET:    wave_act = ~lvl;
      default:            wave_act = cur;
    endcase
  endfunction

  // byte-lane merge of a bus write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      lane_merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  tw_pkg::tw_ctrl_t ctrl_q;
  tw_pkg::tw_mode_t mode;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic        up_q;
  logic        up_d;
  logic [7:0]  cmp_act_q [2];
  logic [7:0]  cmp_buf_q [2];
  logic [1:0]  com [2];
  logic [1:0]  match;
  logic [1:0]  wave_q;
  logic [1:0]  dir_q;
  logic [2:0]  flags_q;
  logic        block_q;
  logic        tick;
  logic [7:0]  top;
  logic        at_top;
  logic        pwm;
  logic        load_buf;
  logic        ovf_set;

  // bus-side signals
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_count;
  logic [31:0] wr_cmp_a;
  logic [31:0] wr_cmp_b;
  logic [31:0] wr_flags;
  logic [31:0] wr_dir;

  tw_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_sel (ctrl_q.clk_sel),
    .tick    (tick)
  );

  // mode decode; unlisted codes behave like the plain free-running counter
  always_comb begin
    case (ctrl_q.wgm)
      tw_pkg::WGM_CTC:      mode = tw_pkg::MODE_CTC;
      tw_pkg::WGM_FAST_FF:  mode = tw_pkg::MODE_FAST;
      tw_pkg::WGM_FAST_CA:  mode = tw_pkg::MODE_FAST;
      tw_pkg::WGM_PHASE_FF: mode = tw_pkg::MODE_PHASE;
      tw_pkg::WGM_PHASE_CA: mode = tw_pkg::MODE_PHASE;
      default:              mode = tw_pkg::MODE_NORMAL;
    endcase
  end

  // top: compare a in clear-on-match and in the high pwm codes, else max
  assign pwm    = (mode == tw_pkg::MODE_FAST) || (mode == tw_pkg::MODE_PHASE);
  assign top    = (mode == tw_pkg::MODE_CTC) || (pwm && ctrl_q.wgm[2]) ?
                  cmp_act_q[0] : tw_pkg::COUNT_MAX;
  assign at_top = (cnt_q == top);
  assign com[0] = ctrl_q.com_a;
  assign com[1] = ctrl_q.com_b;

  // a count write hides matches for the following timer tick
  assign match[0] = (cnt_q == cmp_act_q[0]) && !block_q;
  assign match[1] = (cnt_q == cmp_act_q[1]) && !block_q;

  // next count and direction for one timer tick
  always_comb begin
    cnt_d = cnt_q + 8'h01;
    up_d  = 1'b1;
    case (mode)
      tw_pkg::MODE_CTC: begin
        // a missed match simply wraps through 0xFF to 0x00
        if (match[0]) cnt_d = tw_pkg::COUNT_BOTTOM;
      end
      tw_pkg::MODE_FAST: begin
        if (at_top) cnt_d = tw_pkg::COUNT_BOTTOM;
      end
      tw_pkg::MODE_PHASE: begin
        up_d = up_q;
        if (up_q) begin
          if (at_top) begin
            // top is shown for one tick, then the slope turns
            up_d  = 1'b0;
            cnt_d = (top == tw_pkg::COUNT_BOTTOM) ? top : cnt_q - 8'h01;
          end
        end else if (cnt_q == tw_pkg::COUNT_BOTTOM) begin
          up_d  = 1'b1;
          cnt_d = (top == tw_pkg::COUNT_BOTTOM) ? cnt_q : cnt_q + 8'h01;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: cnt_d = cnt_q + 8'h01;
    endcase
  end

  // counter, direction and match blocking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= tw_pkg::COUNT_BOTTOM;
      up_q    <= 1'b1;
      block_q <= 1'b0;
    end else if (|wr_count) begin
      cnt_q   <= wdata_q[7:0];
      block_q <= 1'b1;
    end else if (tick) begin
      cnt_q   <= cnt_d;
      up_q    <= up_d;
      block_q <= 1'b0;
    end
  end

  // pwm buffers move to the active compare at top (fast: the wrap to bottom)
  assign load_buf = tick && ((mode == tw_pkg::MODE_FAST && at_top) ||
                             (mode == tw_pkg::MODE_PHASE && up_q && at_top));

  // overflow event per mode
  always_comb begin
    case (mode)
      tw_pkg::MODE_FAST:  ovf_set = tick && at_top;
      tw_pkg::MODE_PHASE: ovf_set = tick && (cnt_d == tw_pkg::COUNT_BOTTOM) &&
                                    (cnt_q != tw_pkg::COUNT_BOTTOM);
      default:            ovf_set = tick && (cnt_q == tw_pkg::COUNT_MAX);
    endcase
  end

  // sticky flags; a set in the cycle of a clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= tw_pkg::FLG_RST;
    end else begin
      flags_q[tw_pkg::FLAG_OVF] <= ovf_set ||
        (flags_q[tw_pkg::FLAG_OVF] && !wr_flags[tw_pkg::FLAG_OVF]);
      flags_q[tw_pkg::FLAG_CMP_A] <= (tick && match[0]) ||
        (flags_q[tw_pkg::FLAG_CMP_A] && !wr_flags[tw_pkg::FLAG_CMP_A]);
      flags_q[tw_pkg::FLAG_CMP_B] <= (tick && match[1]) ||
        (flags_q[tw_pkg::FLAG_CMP_B] && !wr_flags[tw_pkg::FLAG_CMP_B]);
    end
  end

  // per-channel compare storage and wave state
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [31:0] wr_cmp;
    logic        bottom_hit;
    assign wr_cmp     = (i == 0) ? wr_cmp_a : wr_cmp_b;
    assign bottom_hit = (cnt_q == tw_pkg::COUNT_BOTTOM);

    // compare buffer and active value
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_buf_q[i] <= tw_pkg::CMP_RST;
        cmp_act_q[i] <= tw_pkg::CMP_RST;
      end else if (|wr_cmp) begin
        cmp_buf_q[i] <= wdata_q[7:0];
        if (!pwm) cmp_act_q[i] <= wdata_q[7:0];
      end else if (load_buf) begin
        cmp_act_q[i] <= cmp_buf_q[i];
      end else if (!pwm) begin
        cmp_act_q[i] <= cmp_buf_q[i];
      end
    end

    // wave state; output mode 0 falls through wave_act unchanged
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave_q[i] <= 1'b0;
      end else if (tick) begin
        case (mode)
          tw_pkg::MODE_FAST: begin
            // bottom action wins so a compare at top gives a steady level
            if (at_top && com[i][1]) begin
              wave_q[i] <= wave_act(com[i], wave_q[i], 1'b1);
            end else if (match[i]) begin
              wave_q[i] <= wave_act(com[i], wave_q[i], 1'b0);
            end
          end
          tw_pkg::MODE_PHASE: begin
            if (match[i]) begin
              // a match at top counts as downward, at bottom as upward
              if (bottom_hit || (up_q && !at_top)) begin
                wave_q[i] <= wave_act(com[i], wave_q[i], 1'b0);
              end else begin
                wave_q[i] <= wave_act(com[i], wave_q[i], 1'b1);
              end
            end else if (bottom_hit && com[i][1]) begin
              // period start: restore the pre-match level for symmetry
              wave_q[i] <= wave_act(com[i], wave_q[i], 1'b1);
            end
          end
          default: begin
            if (match[i]) begin
              wave_q[i] <= wave_act(com[i], wave_q[i], 1'b0);
            end
          end
        endcase
      end
    end
  end

  // pins: wave shows only with output direction and a non-zero output mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_a    <= 1'b0;
      wave_out_a_oe <= 1'b0;
      wave_out_b    <= 1'b0;
      wave_out_b_oe <= 1'b0;
    end else begin
      wave_out_a    <= dir_q[0] && (com[0] != tw_pkg::COM_OFF) && wave_q[0];
      wave_out_a_oe <= dir_q[0];
      wave_out_b    <= dir_q[1] && (com[1] != tw_pkg::COM_OFF) && wave_q[1];
      wave_out_b_oe <= dir_q[1];
    end
  end

  // control and direction registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= tw_pkg::CTRL_RST;
      dir_q  <= tw_pkg::DIR_RST;
    end else begin
      if (|wr_ctrl) ctrl_q <= wr_ctrl[$bits(tw_pkg::tw_ctrl_t)-1:0];
      if (|wr_dir)  dir_q  <= wr_dir[1:0];
    end
  end

  // write address and data are taken in either order; response after both
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // decoded write strobes: control carries merged data, flags and direction lane-0 bits, count and compare a lane-0 flag; zero when not addressed
  always_comb begin
    wr_ctrl  = 32'h0000_0000;
    wr_count = 32'h0000_0000;
    wr_cmp_a = 32'h0000_0000;
    wr_cmp_b = 32'h0000_0000;
    wr_flags = 32'h0000_0000;
    wr_dir   = 32'h0000_0000;
    if (do_write) begin
      if (awaddr_q == tw_pkg::ADDR_CTRL) begin
        wr_ctrl = lane_merge({22'h000000, ctrl_q}, wdata_q, wstrb_q);
        wr_ctrl = {1'b1, 21'h00000, wr_ctrl[9:0]}; // top bit marks a write of zero
      end else if (awaddr_q == tw_pkg::ADDR_COUNT) begin
        wr_count = {31'h00000000, wstrb_q[0]};
      end else if (awaddr_q == tw_pkg::ADDR_CMP_A) begin
        wr_cmp_a = {31'h00000000, wstrb_q[0]};
      end else if (awaddr_q == tw_pkg::ADDR_CMP_B) begin
        wr_cmp_b = {31'h00000000, wstrb_q[0]};
      end else if (awaddr_q == tw_pkg::ADDR_FLAGS) begin
        wr_flags = wstrb_q[0] ? {29'h00000000, wdata_q[2:0]} : 32'h0000_0000;
      end else if (awaddr_q == tw_pkg::ADDR_DIR) begin
        wr_dir = wstrb_q[0] ? {30'h00000000, wdata_q[1:0]} | 32'h8000_0000
                            : 32'h0000_0000;
      end
    end
  end

  // write channels: one write in flight, readies drop until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tw_pkg::RESP_OKAY;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (!aw_hold_q && !s_axi_bvalid) s_axi_awready <= 1'b1;
      if (!w_hold_q && !s_axi_bvalid)  s_axi_wready  <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_hold_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_hold_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == tw_pkg::ADDR_CTRL || awaddr_q == tw_pkg::ADDR_COUNT ||
            awaddr_q == tw_pkg::ADDR_CMP_A || awaddr_q == tw_pkg::ADDR_CMP_B ||
            awaddr_q == tw_pkg::ADDR_FLAGS || awaddr_q == tw_pkg::ADDR_DIR) begin
          s_axi_bresp <= tw_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= tw_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tw_pkg::RESP_OKAY;
      if (s_axi_araddr == tw_pkg::ADDR_CTRL) begin
        s_axi_rdata <= {22'h000000, ctrl_q};
      end else if (s_axi_araddr == tw_pkg::ADDR_COUNT) begin
        s_axi_rdata <= {24'h000000, cnt_q};
      end else if (s_axi_araddr == tw_pkg::ADDR_CMP_A) begin
        s_axi_rdata <= {24'h000000, cmp_buf_q[0]};
      end else if (s_axi_araddr == tw_pkg::ADDR_CMP_B) begin
        s_axi_rdata <= {24'h000000, cmp_buf_q[1]};
      end else if (s_axi_araddr == tw_pkg::ADDR_FLAGS) begin
        s_axi_rdata <= {29'h00000000, flags_q};
      end else if (s_axi_araddr == tw_pkg::ADDR_DIR) begin
        s_axi_rdata <= {30'h00000000, dir_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= tw_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // tw_timer8

// ---- testbench/tw_timer8_sva.sv ----
// checker: bus handshake order and pin gating of the waveform timer
// assumes it is bound onto tw_timer8, single aclk domain
`timescale 1ns/1ns
module tw_timer8_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe,
  input wire logic wave_out_b,
  input wire logic wave_out_b_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // an undriven pin must never carry the wave
  a_pin_hidden_a: assert property (!wave_out_a_oe |-> !wave_out_a)
    else $error("wave a shown while pin a undriven");
  a_pin_hidden_b: assert property (!wave_out_b_oe |-> !wave_out_b)
    else $error("wave b shown while pin b undriven");
  // reset must quiet every answer one edge later
  a_reset_quiet: assert property (disable iff (1'h0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !wave_out_a_oe)
    else $error("outputs active after reset edge");
  // write response follows the paired address and data
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during response");
  // one read at a time, answered on the next edge
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
  c_wave_rise: cover property (wave_out_a_oe && $rose(wave_out_a));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // tw_timer8_sva

bind tw_timer8 tw_timer8_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wave_out_a, .wave_out_a_oe,
  .wave_out_b, .wave_out_b_oe);

// ---- testbench/tw_pin_load.sv ----
// pin load model: pull-down on a wave pin plus pulse and period meters
// assumes the timer changes its pins only just after rising aclk edges
`timescale 1ns/1ns
module tw_pin_load (
  input  wire logic aclk,
  input  wire logic wave,
  input  wire logic oe,
  output logic      pin,
  output int        hi_len,
  output int        per_len,
  output int        rises
);
  int   cnt = 0;
  logic pin_q = 1'h0;
  // pull-down: an undriven pin reads low, never the last wave value
  assign pin = oe ? wave : 1'h0;
  // lengths in aclk cycles; measured between edges so a partial first pulse is ignored
  always_ff @(posedge aclk) begin
    pin_q <= pin;
    cnt <= cnt + 1;
    if (pin && !pin_q) begin
      per_len <= cnt;
      cnt <= 1;
      rises <= rises + 1;
    end
    if (!pin && pin_q) hi_len <= cnt;
  end
endmodule // tw_pin_load

// ---- testbench/tw_timer8_test.sv ----
// self-checking bench for the 8-bit waveform timer
// assumes tw_pkg compiled first and the checker bound from its own file
`timescale 1ns/1ns
module tw_timer8_test;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe, pin_a;
  int hi_len, per_len, rises, n, num_errors = 0, checks = 0;
  always #25 aclk = ~aclk;
  tw_timer8 dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_out_a, .wave_out_a_oe,
    .wave_out_b, .wave_out_b_oe);
  tw_pin_load u_load (.aclk, .wave(wave_out_a), .oe(wave_out_a_oe), .pin(pin_a),
    .hi_len, .per_len, .rises);
  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    wrap_up();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // prescale factor per clock select code
  function automatic int div_of(input int s);
    int t[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[s];
  endfunction
  // each channel released at the edge that takes it; sampled mid-cycle to avoid races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, b;
    int k;
    b = 1'h0;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      if (++k > 50) hang();
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ta, r;
    logic [31:0] got;
    int k;
    r = 1'h0;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      got = s_axi_rdata;
      resp = s_axi_rresp;
      if (++k > 50) hang();
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    cmp(got, exp);
    cmp(32'(resp), 32'(er));
  endtask
  // stop, zero, clear flags, load compare while unbuffered, then start
  task automatic setup(input logic [2:0] w, input logic [1:0] c, input logic [2:0] s,
                       input logic [7:0] v);
    wr(tw_pkg::ADDR_CTRL, 32'h0);
    wr(tw_pkg::ADDR_COUNT, 32'h0);
    wr(tw_pkg::ADDR_FLAGS, 32'h7);
    wr(tw_pkg::ADDR_CMP_A, {24'h0, v});
    wr(tw_pkg::ADDR_DIR, 32'h3);
    wr(tw_pkg::ADDR_CTRL, {22'h0, s, 2'h0, c, w});
  endtask
  task automatic run(input logic [2:0] w, input logic [1:0] c, input logic [2:0] s,
                     input logic [7:0] v, input int hi, input int per, input logic [2:0] fl);
    int k, r0;
    k = 0;
    setup(w, c, s, v);
    r0 = rises;
    while (rises < r0 + 3) begin
      @(posedge aclk);
      if (++k > 20000) hang();
    end
    cmp(hi_len, hi);
    cmp(per_len, per);
    rd_chk(tw_pkg::ADDR_FLAGS, {29'h0, fl}, tw_pkg::RESP_OKAY);
  endtask
  // a level that must hold over more than one whole period
  task automatic flat(input logic [2:0] w, input logic [1:0] c, input logic [7:0] v,
                      input logic lvl);
    int r0;
    setup(w, c, 3'h1, v);
    repeat (600) @(posedge aclk);
    r0 = rises;
    repeat (600) @(posedge aclk);
    cmp(rises, r0);
    cmp(32'(pin_a), 32'(lvl));
  endtask
  initial begin
    void'($urandom(8));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'h0, tw_pkg::RESP_OKAY);
    rd_chk(8'h18, 32'h0, tw_pkg::RESP_SLVERR);
    wr(8'h18, 32'hFF);
    cmp(32'(resp), 32'(tw_pkg::RESP_SLVERR));
    for (int s = 1; s < 5; s++)
      run(tw_pkg::WGM_CTC, tw_pkg::COM_TOGGLE, 3'(s), 8'h02, 3 * div_of(s), 6 * div_of(s),
          3'h6);
    n = 1 + $urandom % 60;
    run(tw_pkg::WGM_CTC, tw_pkg::COM_TOGGLE, 3'h1, 8'(n), n + 1, 2 * n + 2, 3'h6);
    wr(tw_pkg::ADDR_CMP_A, 32'h0A);
    wr(tw_pkg::ADDR_COUNT, 32'h80);
    wr(tw_pkg::ADDR_FLAGS, 32'h7);
    repeat (300) @(posedge aclk);
    rd_chk(tw_pkg::ADDR_FLAGS, 32'h7, tw_pkg::RESP_OKAY);
    n = 1 + $urandom % 250;
    run(tw_pkg::WGM_FAST_FF, tw_pkg::COM_CLEAR, 3'h1, 8'(n), n + 1, 256, 3'h7);
    run(tw_pkg::WGM_FAST_FF, tw_pkg::COM_SET, 3'h1, 8'(n), 255 - n, 256, 3'h7);
    run(tw_pkg::WGM_FAST_FF, tw_pkg::COM_CLEAR, 3'h1, 8'h00, 1, 256, 3'h7);
    n = 2 + $urandom % 60;
    run(tw_pkg::WGM_FAST_CA, tw_pkg::COM_TOGGLE, 3'h1, 8'(n), n + 1, 2 * n + 2, 3'h7);
    n = 1 + $urandom % 250;
    run(tw_pkg::WGM_PHASE_FF, tw_pkg::COM_CLEAR, 3'h1, 8'(n), 2 * n, 510, 3'h7);
    run(tw_pkg::WGM_PHASE_FF, tw_pkg::COM_SET, 3'h1, 8'(n), 510 - 2 * n, 510, 3'h7);
    run(tw_pkg::WGM_PHASE_CA, tw_pkg::COM_TOGGLE, 3'h1, 8'(n), 2 * n, 4 * n, 3'h7);
    flat(tw_pkg::WGM_FAST_FF, tw_pkg::COM_CLEAR, 8'hFF, 1'h1);
    flat(tw_pkg::WGM_PHASE_FF, tw_pkg::COM_CLEAR, 8'h00, 1'h0);
    flat(tw_pkg::WGM_PHASE_FF, tw_pkg::COM_CLEAR, 8'hFF, 1'h1);
    flat(tw_pkg::WGM_PHASE_FF, tw_pkg::COM_SET, 8'h00, 1'h1);
    flat(tw_pkg::WGM_CTC, tw_pkg::COM_OFF, 8'h02, 1'h0);
    run(tw_pkg::WGM_CTC, tw_pkg::COM_TOGGLE, 3'h1, 8'h03, 4, 8, 3'h6);
    wr(tw_pkg::ADDR_DIR, 32'h0);
    repeat (3) @(posedge aclk);
    cmp({28'h0, wave_out_a_oe, pin_a, wave_out_b_oe, wave_out_b}, 32'h0);
    wrap_up();
  end
endmodule // tw_timer8_test
